// File: icc_cache_ctrl.sv
/*
  internal cache control: two-way write-through cache with line fill,
  mode bits, flush instructions with special cycles, page attribute outputs.
  assumes the bus answers each request with one bus_ack_in pulse and that
  the core holds a request until core_done_out pulses.
*/
// Contract
// - lines are 128 bits, always fully filled
// - lines map to 16-byte aligned blocks
// - fill whole block, then mark valid
// - enabled writes update cache and memory
// - reset comes up with caching enabled
// - disabled bit: read hits use cache only
// - no-write-through: write hits skip memory
// - stale lines are never written back
// - disable alone: no allocation, hits serve
// - both bits: hits respond, no memory write on hits
// - invalid bit pair raises protection fault
// - invalidate clears lines, emits flush cycle
// - writeback flush emits writeback then flush
// - code writes update cache and memory
// - non-paged cycles use page base bits
// - table entry fetch uses directory bits
// - paged accesses use table entry bits
// - paging off forces both attributes zero
// - inhibit bit four blocks caching always
// - inhibit clear: honour cache enable input
// - cache disable forces inhibit output zero
// - write-through bit three only drives pin
`timescale 1ns/1ps
module icc_cache_ctrl (
  // clock and reset
  input  wire logic                           ref_clk_in,
  input  wire logic                           sys_rst_in,
  // machine control writes
  input  wire logic                           ctrl_wr_in,
  input  wire logic                           cache_disable_bit_in,
  input  wire logic                           no_write_through_bit_in,
  input  wire logic                           paging_en_in,
  // page attribute sources
  input  wire logic [icc_pkg::WORD_W-1:0]     page_base_ctrl_reg_in,
  input  wire logic [icc_pkg::WORD_W-1:0]     dir_entry_in,
  input  wire logic [icc_pkg::WORD_W-1:0]     table_entry_in,
  // flush instructions
  input  wire logic                           invalidate_instruction_in,
  input  wire logic                           writeback_flush_instruction_in,
  // core access
  input  wire icc_pkg::icc_req_s              core_req_in,
  output logic [icc_pkg::WORD_W-1:0]          core_rdata_out,
  output logic                                core_done_out,
  output logic                                core_hit_out,
  // external bus
  output icc_pkg::icc_bus_s                   bus_req_out,
  input  wire logic                           bus_ack_in,
  input  wire logic [icc_pkg::WORD_W-1:0]     bus_rdata_in,
  input  wire logic                           cache_enable_input_in,
  output icc_pkg::icc_spc_e                   special_cycle_out,
  // status
  output logic                                cache_disable_bit_out,
  output logic                                no_write_through_bit_out,
  output logic                                gp_fault_out,
  output logic [icc_pkg::WORD_W-1:0]          gp_err_code_out,
  output logic                                flush_busy_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ICC_IDLE,       // waiting for an access
    ICC_MEM_RD,     // uncached single read
    ICC_MEM_WR,     // write to memory
    ICC_FILL,       // line fill, four words
    ICC_DONE,       // one-cycle completion
    ICC_SPC_WB,     // writeback special cycle
    ICC_SPC_FL      // flush special cycle
  } icc_state_e;

  icc_state_e                             state_q;          // controller state
  logic                                   cd_q;             // cache disable mode bit
  logic                                   nw_q;             // no write through mode bit
  logic [icc_pkg::SETS*icc_pkg::WAYS-1:0] valid_q;          // per line valid flags
  logic [icc_pkg::TAG_W-1:0]              tag_q  [icc_pkg::SETS*icc_pkg::WAYS];  // tags
  logic [icc_pkg::LINE_BITS-1:0]          data_q [icc_pkg::SETS*icc_pkg::WAYS];  // line data
  logic [icc_pkg::SETS-1:0]               lru_q;            // way to replace next per set
  logic [icc_pkg::WSEL_W-1:0]             fill_cnt_q;       // fill word counter
  logic                                   fill_ok_q;        // cache enable held through fill
  logic [icc_pkg::LINE_BITS-1:0]          fill_buf_q;       // words gathered before commit
  icc_pkg::icc_bus_s                      bus_q;            // registered bus request
  icc_pkg::icc_spc_e                      spc_q;            // registered special cycle
  logic [icc_pkg::WORD_W-1:0]             rdata_q;          // read data to core
  logic                                   done_q;           // completion pulse
  logic                                   hit_q;            // last access hit
  logic                                   gp_q;             // protection fault pulse
  logic                                   spc_wb_pend_q;    // flush sequence under way

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [icc_pkg::SET_W-1:0]  set_idx  = core_req_in.addr[icc_pkg::TAG_LO-1:icc_pkg::OFF_BITS];
  wire [icc_pkg::TAG_W-1:0]  acc_tag  = core_req_in.addr[icc_pkg::ADDR_W-1:icc_pkg::TAG_LO];
  wire [icc_pkg::WSEL_W-1:0] word_sel = core_req_in.addr[icc_pkg::WSEL_LO+icc_pkg::WSEL_W-1:icc_pkg::WSEL_LO];
  wire [icc_pkg::ADDR_W-1:0] line_base = {core_req_in.addr[icc_pkg::ADDR_W-1:icc_pkg::OFF_BITS],
                                          icc_pkg::LINE_ALIGN};
  logic [icc_pkg::WAYS-1:0]  way_hit;

  // per-way tag compare against valid lines only
  genvar gw;
  generate
    for (gw = 0; gw < icc_pkg::WAYS; gw++) begin : g_cmp
      assign way_hit[gw] = valid_q[set_idx*icc_pkg::WAYS+gw] &&
                           (tag_q[set_idx*icc_pkg::WAYS+gw] == acc_tag);
    end
  endgenerate

  wire       any_hit  = |way_hit;
  wire       hit_way  = way_hit[1];
  wire [3:0] hit_line = {set_idx, hit_way};
  wire [3:0] vic_line = {set_idx, lru_q[set_idx]};
  wire       access   = core_req_in.rd | core_req_in.wr;

  // page attribute source; paging off forces zero
  logic [icc_pkg::WORD_W-1:0] attr_src;
  always_comb begin
    case (core_req_in.src)
      icc_pkg::ICC_SRC_NOPAGE:    attr_src = page_base_ctrl_reg_in;
      icc_pkg::ICC_SRC_PTE_FETCH: attr_src = dir_entry_in;
      icc_pkg::ICC_SRC_PAGED:     attr_src = table_entry_in;
      default:                    attr_src = page_base_ctrl_reg_in;
    endcase
  end
  wire pcd_raw = paging_en_in & attr_src[icc_pkg::PCD_POS];
  wire pwt_out = paging_en_in & attr_src[icc_pkg::PWT_POS];
  wire pcd_out = pcd_raw & ~cd_q;
  // inhibit bit blocks caching even with enable asserted; allocation also needs cd clear
  wire may_alloc = ~cd_q & ~pcd_raw;

  // write hit skips memory only while no-write-through is set
  wire wr_skip_mem = nw_q;
  wire bad_ctrl    = ctrl_wr_in & ~cache_disable_bit_in & no_write_through_bit_in;
  wire flush_req   = invalidate_instruction_in | writeback_flush_instruction_in;

  // ----------------------------------------------------------------
  // mode bits; invalid pair is refused and faults
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cd_q <= 1'b0;
      nw_q <= 1'b0;
      gp_q <= 1'b0;
    end else begin
      gp_q <= bad_ctrl;
      if (ctrl_wr_in && !bad_ctrl) begin
        cd_q <= cache_disable_bit_in;
        nw_q <= no_write_through_bit_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // main controller
  // ----------------------------------------------------------------
  // note: lines are never written back, so stale data under nw just drops
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q       <= ICC_IDLE;
      valid_q       <= '0;
      lru_q         <= '0;
      fill_cnt_q    <= '0;
      fill_ok_q     <= 1'b0;
      fill_buf_q    <= '0;
      bus_q         <= '0;
      spc_q         <= icc_pkg::ICC_SPC_NONE;
      rdata_q       <= '0;
      done_q        <= 1'b0;
      hit_q         <= 1'b0;
      spc_wb_pend_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ICC_IDLE: begin
          if (flush_req) begin
            valid_q       <= '0;
            // busy flag held in its own flop so the status output needs no gates
            spc_wb_pend_q <= 1'b1;
            if (writeback_flush_instruction_in) begin
              spc_q   <= icc_pkg::ICC_SPC_WRITEBACK;
              state_q <= ICC_SPC_WB;
            end else begin
              spc_q   <= icc_pkg::ICC_SPC_FLUSH;
              state_q <= ICC_SPC_FL;
            end
          end else if (access) begin
            hit_q <= any_hit;
            if (core_req_in.rd && any_hit) begin
              // read hit served locally in every mode
              rdata_q <= data_q[hit_line][word_sel*icc_pkg::WORD_W +: icc_pkg::WORD_W];
              lru_q[set_idx] <= ~hit_way;
              done_q  <= 1'b1;
              state_q <= ICC_DONE;
            end else if (core_req_in.wr) begin
              // write hit updates the line, including code lines
              if (any_hit) begin
                data_q[hit_line][word_sel*icc_pkg::WORD_W +: icc_pkg::WORD_W] <= core_req_in.wdata;
              end
              if (any_hit && wr_skip_mem) begin
                done_q  <= 1'b1;
                state_q <= ICC_DONE;
              end else begin
                bus_q <= '{rd: 1'b0, wr: 1'b1, addr: core_req_in.addr,
                           wdata: core_req_in.wdata, page_cache_inhibit: pcd_out, page_write_thru: pwt_out};
                state_q <= ICC_MEM_WR;
              end
            end else if (may_alloc) begin
              // miss: fill the whole aligned line
              bus_q <= '{rd: 1'b1, wr: 1'b0, addr: line_base,
                         wdata: '0, page_cache_inhibit: pcd_out, page_write_thru: pwt_out};
              fill_cnt_q <= '0;
              fill_ok_q  <= 1'b1;
              state_q    <= ICC_FILL;
            end else begin
              bus_q <= '{rd: 1'b1, wr: 1'b0, addr: core_req_in.addr,
                         wdata: '0, page_cache_inhibit: pcd_out, page_write_thru: pwt_out};
              state_q <= ICC_MEM_RD;
            end
          end
        end
        ICC_MEM_RD: begin
          if (bus_ack_in) begin
            rdata_q <= bus_rdata_in;
            bus_q   <= '0;
            done_q  <= 1'b1;
            state_q <= ICC_DONE;
          end
        end
        ICC_MEM_WR: begin
          if (bus_ack_in) begin
            bus_q   <= '0;
            done_q  <= 1'b1;
            state_q <= ICC_DONE;
          end
        end
        ICC_FILL: begin
          if (bus_ack_in) begin
            // enable is sampled per word; one refusal makes the line uncacheable
            fill_ok_q <= fill_ok_q & cache_enable_input_in;
            fill_buf_q[fill_cnt_q*icc_pkg::WORD_W +: icc_pkg::WORD_W] <= bus_rdata_in;
            if (fill_cnt_q == word_sel) begin
              rdata_q <= bus_rdata_in;
            end
            if (fill_cnt_q == icc_pkg::LAST_WORD) begin
              bus_q <= '0;
              if (fill_ok_q && cache_enable_input_in) begin
                // commit only a complete line
                data_q[vic_line] <= {bus_rdata_in,
                                     fill_buf_q[icc_pkg::LINE_BITS-icc_pkg::WORD_W-1:0]};
                tag_q[vic_line]   <= acc_tag;
                valid_q[vic_line] <= 1'b1;
                lru_q[set_idx]    <= ~lru_q[set_idx];
              end
              done_q  <= 1'b1;
              state_q <= ICC_DONE;
            end else begin
              fill_cnt_q <= fill_cnt_q + 1'b1;
              bus_q.addr[icc_pkg::WSEL_LO+icc_pkg::WSEL_W-1:icc_pkg::WSEL_LO] <= fill_cnt_q + 1'b1;
            end
          end
        end
        ICC_DONE: begin
          // one idle cycle lets the core drop its request
          state_q <= ICC_IDLE;
        end
        ICC_SPC_WB: begin
          if (bus_ack_in) begin
            spc_q   <= icc_pkg::ICC_SPC_FLUSH;
            state_q <= ICC_SPC_FL;
          end
        end
        ICC_SPC_FL: begin
          if (bus_ack_in) begin
            spc_q         <= icc_pkg::ICC_SPC_NONE;
            spc_wb_pend_q <= 1'b0;
            done_q        <= 1'b1;
            state_q       <= ICC_DONE;
          end
        end
        default: begin
          state_q <= ICC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs from flip-flops, error code tied to zero
  // ----------------------------------------------------------------
  assign core_rdata_out           = rdata_q;
  assign core_done_out            = done_q;
  assign core_hit_out             = hit_q;
  assign bus_req_out              = bus_q;
  assign special_cycle_out        = spc_q;
  assign cache_disable_bit_out    = cd_q;
  assign no_write_through_bit_out = nw_q;
  assign gp_fault_out             = gp_q;
  assign gp_err_code_out          = '0;
  assign flush_busy_out           = spc_wb_pend_q;           // set at take, cleared on flush ack

endmodule

// File: icc_cache_ctrl_bench.sv
/*
  self-checking bench for the internal cache control block.
  assumes the memory model answers on the bus; inputs change on falling edges.
*/
`timescale 1ns/1ps
module icc_cache_ctrl_bench;
  logic clk, rst, ctrl_wr, cd, nw, pg, inv, wbf, cache_enable_input, ack, kx, done, hit, cdo, nwo, gp, busy;
  logic [31:0] base, dir, tbl, rdat, cq, gpc, la, ld;
  logic [15:0] rc, wc;
  logic [1:0] lat;
  logic [3:0] dly;
  icc_pkg::icc_req_s req;
  icc_pkg::icc_bus_s bus;
  icc_pkg::icc_spc_e spc;
  int errors, checks_done, cyc;
  icc_cache_ctrl DUT (.ref_clk_in(clk), .sys_rst_in(rst), .ctrl_wr_in(ctrl_wr), .cache_disable_bit_in(cd),
    .no_write_through_bit_in(nw), .paging_en_in(pg), .page_base_ctrl_reg_in(base), .dir_entry_in(dir),
    .table_entry_in(tbl), .invalidate_instruction_in(inv), .writeback_flush_instruction_in(wbf),
    .core_req_in(req), .core_rdata_out(cq), .core_done_out(done), .core_hit_out(hit), .bus_req_out(bus),
    .bus_ack_in(ack), .bus_rdata_in(rdat), .cache_enable_input_in(kx), .special_cycle_out(spc),
    .cache_disable_bit_out(cdo), .no_write_through_bit_out(nwo), .gp_fault_out(gp),
    .gp_err_code_out(gpc), .flush_busy_out(busy));
  icc_mem_model u_mem (.ref_clk_in(clk), .sys_rst_in(rst), .bus_req_in(bus), .special_in(spc), .ken_in(cache_enable_input),
    .delay_in(dly), .ack_out(ack), .rdata_out(rdat), .ken_out(kx), .rd_cnt_out(rc), .wr_cnt_out(wc),
    .last_addr_out(la), .last_wdata_out(ld), .last_attr_out(lat));
  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] mw(input logic [31:0] a);
    return a ^ 32'h5A5A_0000; // memory contents by address
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one core access, held until done, dropped at once, then one idle cycle
  task automatic acc(input logic w, input logic [31:0] a, d, input icc_pkg::icc_src_e s, output logic [31:0] q);
    int n;
    n = 0;
    req <= '{rd: !w, wr: w, addr: a, wdata: d, src: s};
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 100);
    chk(32'(n < 100), 32'h1);
    q = cq;
    req <= '0;
    @(negedge clk);
  endtask
  task automatic mode(input logic c, input logic w, output logic g);
    ctrl_wr <= 1'b1;
    cd <= c;
    nw <= w;
    @(negedge clk);
    ctrl_wr <= 1'b0;
    g = gp;
    @(negedge clk);
  endtask
  // read twice; c says whether the second read stays off the bus
  task automatic miss2(input logic [31:0] a, input logic c);
    logic [31:0] q;
    logic [15:0] r;
    acc(1'b0, a, 32'h0, icc_pkg::ICC_SRC_PAGED, q);
    chk(q, mw(a));
    r = rc;
    acc(1'b0, a, 32'h0, icc_pkg::ICC_SRC_PAGED, q);
    chk(32'(rc == r), 32'(c));
  endtask
  // pulse a flush instruction, log special cycles at each ack
  task automatic fl(input logic wb, output logic [3:0] sq);
    int n;
    sq = 4'h0;
    n = 0;
    if (wb) wbf <= 1'b1;
    else inv <= 1'b1;
    @(negedge clk);
    inv <= 1'b0;
    wbf <= 1'b0;
    while (busy === 1'b1 && n < 50) begin
      if (ack === 1'b1) sq = {sq[1:0], spc};
      @(negedge clk);
      n++;
    end
    chk(32'(n < 50), 32'h1);
    @(negedge clk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_fill();
    logic [31:0] q;
    logic [15:0] r;
    r = rc;
    acc(1'b0, 32'h1000_0018, 32'h0, icc_pkg::ICC_SRC_PAGED, q);
    chk(q, mw(32'h1000_0018));
    chk(32'(rc - r), 32'h4);
    chk(la, 32'h1000_001C);
    acc(1'b0, 32'h1000_0014, 32'h0, icc_pkg::ICC_SRC_PAGED, q);
    chk({q[30:0], hit}, {mw(32'h1000_0014) << 1} | 32'h1);
    chk(32'(rc - r), 32'h4);
    miss2(32'h3000_0010, 1'b1);
  endtask
  task automatic t_modes();
    logic [31:0] q;
    logic [15:0] r, w;
    logic g;
    w = wc;
    acc(1'b1, 32'h1000_0014, 32'hCAFE_0001, icc_pkg::ICC_SRC_PAGED, q);
    chk(ld, 32'hCAFE_0001);
    chk(32'(wc - w), 32'h1);
    mode(1'b1, 1'b1, g);
    r = rc;
    w = wc;
    acc(1'b1, 32'h1000_0014, 32'hBEEF_0002, icc_pkg::ICC_SRC_PAGED, q);
    chk(32'(wc - w), 32'h0);
    acc(1'b0, 32'h1000_0014, 32'h0, icc_pkg::ICC_SRC_PAGED, q);
    chk(q, 32'hBEEF_0002);
    chk(32'(rc), 32'(r));
    mode(1'b1, 1'b0, g);
    miss2(32'h2000_0020, 1'b0);
    mode(1'b0, 1'b0, g);
    chk(32'(wc - w), 32'h0);
    mode(1'b0, 1'b1, g);
    chk(gpc, 32'h0);
    chk(32'(g), 32'h1);
    chk(32'({cdo, nwo}), 32'h0);
  endtask
  task automatic t_flush();
    logic [3:0] sq;
    fl(1'b0, sq);
    chk(32'(sq), 32'(icc_pkg::ICC_SPC_FLUSH));
    miss2(32'h1000_0018, 1'b1);
    fl(1'b1, sq);
    chk(32'(sq), 32'({icc_pkg::ICC_SPC_WRITEBACK, icc_pkg::ICC_SPC_FLUSH}));
  endtask
  task automatic t_attr();
    logic [31:0] q;
    logic [1:0] ex[4];
    logic g;
    ex = '{2'h2, 2'h1, 2'h3, 2'h2};
    {base, dir, tbl, dly} = {32'h10, 32'h08, 32'h18, 4'h3};
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, 32'h4000_0000, 32'h0, icc_pkg::icc_src_e'(s), q);
      chk(32'(lat), 32'(ex[s]));
    end
    pg <= 1'b0;
    acc(1'b1, 32'h4000_0000, 32'h0, icc_pkg::ICC_SRC_PAGED, q);
    chk(32'(lat), 32'h0);
    pg <= 1'b1;
    mode(1'b1, 1'b0, g);
    acc(1'b1, 32'h4000_0000, 32'h0, icc_pkg::ICC_SRC_PAGED, q);
    chk(32'(lat), 32'h1);
    mode(1'b0, 1'b0, g);
    tbl <= 32'h10;
    miss2(32'h5000_0000, 1'b0);
    {tbl, cache_enable_input, dly} = {32'h0, 1'b0, 4'h0};
    miss2(32'h6000_0000, 1'b0);
    cache_enable_input = 1'b1;
    miss2(32'h6000_0000, 1'b1);
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    {rst, ctrl_wr, cd, nw, inv, wbf, pg, cache_enable_input, dly} = {6'h20, 2'h3, 4'h0};
    {base, dir, tbl, req} = '0;
    repeat (4) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'({cdo, nwo}), 32'h0);
    t_fill();
    t_modes();
    t_flush();
    t_attr();
    stop_test();
  end
endmodule

// File: icc_cache_ctrl_sva.sv
/*
  port checker for the internal cache control block.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module icc_chk (
  // clock and reset
  input wire logic                       ref_clk_in,
  input wire logic                       sys_rst_in,
  // mode control
  input wire logic                       ctrl_wr_in,
  input wire logic                       cache_disable_bit_in,
  input wire logic                       no_write_through_bit_in,
  input wire logic                       paging_en_in,
  // bus side
  input wire icc_pkg::icc_bus_s          bus_req_out,
  input wire logic                       bus_ack_in,
  input wire icc_pkg::icc_spc_e          special_cycle_out,
  // status
  input wire logic                       cache_disable_bit_out,
  input wire logic                       no_write_through_bit_out,
  input wire logic                       gp_fault_out,
  input wire logic [icc_pkg::WORD_W-1:0] gp_err_code_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // refused pair of mode bits
  wire bad = ctrl_wr_in && !cache_disable_bit_in && no_write_through_bit_in;
  // a memory cycle is standing on the bus
  wire busy = bus_req_out.rd || bus_req_out.wr;
  a_reset_mode: assert property ($fell(sys_rst_in) |-> !cache_disable_bit_out && !no_write_through_bit_out)
    else $error("mode bits not clear after reset");
  a_bad_fault: assert property (bad |=> gp_fault_out)
    else $error("refused mode write gave no fault");
  a_fault_code: assert property (gp_fault_out |-> gp_err_code_out == 32'h0000_0000)
    else $error("fault error code not zero");
  a_bad_kept: assert property (bad |=> $stable(cache_disable_bit_out) && $stable(no_write_through_bit_out))
    else $error("refused mode write changed the mode");
  a_mode_load: assert property (ctrl_wr_in && !bad |=> cache_disable_bit_out == $past(cache_disable_bit_in)
    && no_write_through_bit_out == $past(no_write_through_bit_in))
    else $error("mode write not taken");
  a_nopage_attr: assert property (busy && !paging_en_in |-> !bus_req_out.page_cache_inhibit && !bus_req_out.page_write_thru)
    else $error("page attributes set with paging off");
  a_cd_inhibit: assert property (busy && cache_disable_bit_out |-> !bus_req_out.page_cache_inhibit)
    else $error("inhibit output set while cache disabled");
  a_wb_then_flush: assert property (special_cycle_out == icc_pkg::ICC_SPC_WRITEBACK && bus_ack_in
    |=> special_cycle_out == icc_pkg::ICC_SPC_FLUSH)
    else $error("writeback cycle not followed by flush cycle");
  a_flush_last: assert property (special_cycle_out == icc_pkg::ICC_SPC_FLUSH && bus_ack_in
    |=> special_cycle_out == icc_pkg::ICC_SPC_NONE)
    else $error("special cycle after flush cycle");
  a_req_held: assert property (busy && !bus_ack_in |=> $stable(bus_req_out))
    else $error("bus request changed before ack");
endmodule

bind icc_cache_ctrl icc_chk u_chk (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .ctrl_wr_in(ctrl_wr_in),
  .cache_disable_bit_in(cache_disable_bit_in), .no_write_through_bit_in(no_write_through_bit_in),
  .paging_en_in(paging_en_in), .bus_req_out(bus_req_out), .bus_ack_in(bus_ack_in),
  .special_cycle_out(special_cycle_out), .cache_disable_bit_out(cache_disable_bit_out),
  .no_write_through_bit_out(no_write_through_bit_out), .gp_fault_out(gp_fault_out),
  .gp_err_code_out(gp_err_code_out));

// File: icc_mem_model.sv
/*
  system bus memory model: answers each request or special cycle with one ack.
  assumes the block holds its request until the ack edge.
*/
`timescale 1ns/1ps
module icc_mem_model (
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              sys_rst_in,
  // bus from the block
  input  wire icc_pkg::icc_bus_s bus_req_in,
  input  wire icc_pkg::icc_spc_e special_in,
  // scenario knobs
  input  wire logic              ken_in,
  input  wire logic [3:0]        delay_in,
  // answers
  output logic                   ack_out,
  output logic [31:0]            rdata_out,
  output logic                   ken_out,
  // what was seen
  output logic [15:0]            rd_cnt_out,
  output logic [15:0]            wr_cnt_out,
  output logic [31:0]            last_addr_out,
  output logic [31:0]            last_wdata_out,
  output logic [1:0]             last_attr_out
);
  logic [3:0]  wait_q;  // cycles spent on this request
  logic [31:0] noise_q; // shown when no answer stands
  wire act = bus_req_in.rd | bus_req_in.wr | (special_in != icc_pkg::ICC_SPC_NONE);
  // data only valid in the ack cycle, so a sloppy sampler sees garbage
  assign rdata_out = ack_out ? (bus_req_in.addr ^ 32'h5A5A_0000) : noise_q;
  assign ken_out = ack_out ? ken_in : ~ken_in;
  // ack after delay_in + 1 waiting cycles, one cycle wide
  always_ff @(posedge ref_clk_in) begin
    noise_q <= sys_rst_in ? 32'h0 : ~noise_q + 32'h1;
    wait_q <= (sys_rst_in || ack_out || !act) ? 4'h0 : wait_q + 4'h1;
    ack_out <= !sys_rst_in && !ack_out && act && (wait_q >= delay_in);
    if (sys_rst_in) begin
      rd_cnt_out <= 16'h0;
      wr_cnt_out <= 16'h0;
    end else if (ack_out && (bus_req_in.rd || bus_req_in.wr)) begin
      rd_cnt_out <= rd_cnt_out + 16'(bus_req_in.rd);
      wr_cnt_out <= wr_cnt_out + 16'(bus_req_in.wr);
      last_addr_out <= bus_req_in.addr;
      last_wdata_out <= bus_req_in.wdata;
      last_attr_out <= {bus_req_in.page_cache_inhibit, bus_req_in.page_write_thru};
    end
  end
endmodule

// File: icc_pkg.sv
/*
  shared constants and carrier types for the internal cache control block.
  assumes a 32-bit physical address and a 128-bit line, filled as four 32-bit words.
*/
package icc_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 32;                // physical address width
  localparam int WORD_W      = 32;                // bus data width
  localparam int LINE_BITS   = 128;               // one cache line
  localparam int LINE_WORDS  = LINE_BITS / WORD_W;
  localparam int OFF_BITS    = 4;                 // low address bits inside a line
  localparam int WSEL_LO     = 2;                 // word select position
  localparam int WSEL_W      = 2;                 // word select width
  localparam int SETS        = 8;                 // sets held in flip-flops
  localparam int SET_W       = 3;                 // set index width
  localparam int WAYS        = 2;                 // ways per set
  localparam int TAG_LO      = OFF_BITS + SET_W;
  localparam int TAG_W       = ADDR_W - TAG_LO;
  localparam int PCD_POS     = 4;                 // cache-inhibit bit in page entries
  localparam int PWT_POS     = 3;                 // write-through bit in page entries
  localparam logic [WSEL_W-1:0] LAST_WORD = 2'h3;
  localparam logic [OFF_BITS-1:0] LINE_ALIGN = 4'h0;

  // ----------------------------------------------------------------
  // source of the page-level attribute bits
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ICC_SRC_NOPAGE,   // address not made by paging: page base register
    ICC_SRC_PTE_FETCH,// fetching a table entry: directory entry
    ICC_SRC_PAGED,    // data or code: table entry
    ICC_SRC_RSVD
  } icc_src_e;

  // special bus cycle codes
  typedef enum logic [1:0] {
    ICC_SPC_NONE,
    ICC_SPC_WRITEBACK,
    ICC_SPC_FLUSH
  } icc_spc_e;

  // core side access request
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    icc_src_e          src;
  } icc_req_s;

  // external bus request
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic              page_cache_inhibit;
    logic              page_write_thru;
  } icc_bus_s;
endpackage
